// ### spi_busy_pkg.sv
// Shared constants and types for the serial port with busy handshake
package spi_busy_pkg;

    // ****************************************************************
    // Busy, chip select gap and word timing, in serial clock rising edges
    // ****************************************************************
    localparam logic [9:0] BUSY_SHORT_CYC = 10'h008; // 8, inside 3..21
    localparam logic [9:0] BUSY_LONG_CYC = 10'h2E8;  // 744
    localparam int CS_GAP_MIN_CYC = 3;
    localparam int WORD_CYC_MIN = 29;

    // ****************************************************************
    // Reset values and serial-side states
    // ****************************************************************
    localparam logic [1:0] SYNC_RST = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FRAME = 2'b01,
        ST_BUSY = 2'b10
    } link_state_t;

    typedef struct packed {
        logic start;
        logic long_run;
    } busy_start_t;

endpackage : spi_busy_pkg

// ### spi_slave_busy_handshake.sv
// Serial slave port with busy handshake and two clock domains
// Functional notes
// R1: Sample serial input on each rising serial clock edge during a frame.
// R2: Launch each serial output bit from a rising serial clock edge.
// R3: Drive serial output only once chip select is seen asserted.
// R4: Stop driving serial output when chip select is released.
// R5: Master keeps chip select released at least 3 rising clock edges.
// R6: At minimum gap master places release edge precisely before next edge.
// R7: Assert busy on first clock edge after frame end or reset release.
// R8: Ordinary busy lasts 3 to 21 serial clock cycles, then releases.
// R9: Busy after reset or soft reset command lasts at least 744 cycles.
// R10: Master allows at least 29 rising edges per word, gap included.
// R11: Master keeps clocking until busy releases, no frame while busy.
`timescale 1ns/1ps
module spi_slave_busy_handshake
    import spi_busy_pkg::*;
#(
    parameter int WORD_W = 26,
    // Soft reset command code, value arbitrary
    parameter logic [WORD_W-1:0] SOFT_RST_CMD = 26'h2A5A5A5
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic o_busy_n_out,
    output logic o_busy_n_oe,
    input wire logic [WORD_W-1:0] i_tx_data,
    input wire logic i_tx_load,
    output logic [WORD_W-1:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_busy
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [1:0] srst_sync_r;
    logic srst_d_r;
    logic srst;
    link_state_t state_r;
    logic [5:0] bit_cnt_r;
    logic [WORD_W-1:0] rx_sr_r;
    logic [WORD_W-1:0] tx_sr_r;
    logic [WORD_W-1:0] tx_buf_r;
    logic [WORD_W-1:0] rx_hold_r;
    logic rx_tog_r;
    logic [2:0] tx_tog_sync_r;
    logic [9:0] busy_cnt_r;
    logic [9:0] busy_len_r;
    logic long_r;
    busy_start_t go;
    logic word_ok;
    logic [WORD_W-1:0] tx_hold_r;
    logic tx_tog_r;
    logic [2:0] rx_tog_sync_r;
    logic [1:0] busy_sync_r;

    // ****************************************************************
    // Serial clock domain
    // ****************************************************************
    // Reset pin brought into the serial clock domain
    always_ff @(posedge i_sclk) begin
        srst_sync_r <= {srst_sync_r[0], i_rst_n};
        srst_d_r <= srst_sync_r[1];
    end
    assign srst = ~srst_sync_r[1];

    // Busy start events: frame end or reset release
    assign word_ok = (bit_cnt_r == 6'(WORD_W));
    always_comb begin
        go.start = 1'b0;
        go.long_run = 1'b0;
        if (srst_sync_r[1] && !srst_d_r) begin
            go.start = 1'b1; // R7
            go.long_run = 1'b1; // R9
        end else if (state_r == ST_FRAME && i_cs_n) begin
            go.start = 1'b1; // R7
            go.long_run = word_ok && (rx_sr_r == SOFT_RST_CMD); // R9
        end
    end

    // Frame sequencing
    always_ff @(posedge i_sclk) begin
        if (srst) begin
            state_r <= ST_IDLE;
        end else if (go.start) begin
            state_r <= ST_BUSY;
        end else if (state_r == ST_IDLE && !i_cs_n) begin
            state_r <= ST_FRAME;
        end else if (state_r == ST_BUSY && busy_cnt_r == 10'h000) begin
            state_r <= ST_IDLE;
        end
    end

    // Input shifting and bit count
    always_ff @(posedge i_sclk) begin
        if (srst) begin
            bit_cnt_r <= 6'h00;
            rx_sr_r <= '0;
        end else if (!i_cs_n && state_r != ST_BUSY) begin
            rx_sr_r <= {rx_sr_r[WORD_W-2:0], i_sdi}; // R1
            if (state_r == ST_IDLE) begin
                bit_cnt_r <= 6'h01;
            end else if (!word_ok) begin
                bit_cnt_r <= bit_cnt_r + 6'h01;
            end
        end
    end

    // Output shifting, launched on rising edges
    always_ff @(posedge i_sclk) begin
        if (srst) begin
            o_sdo <= 1'b0;
            tx_sr_r <= '0;
        end else if (!i_cs_n && state_r == ST_IDLE) begin
            o_sdo <= tx_buf_r[WORD_W-1]; // R2
            tx_sr_r <= {tx_buf_r[WORD_W-2:0], 1'b0};
        end else if (!i_cs_n && state_r == ST_FRAME) begin
            o_sdo <= tx_sr_r[WORD_W-1]; // R2
            tx_sr_r <= {tx_sr_r[WORD_W-2:0], 1'b0};
        end
    end

    // Output enable follows chip select outside the busy state
    always_ff @(posedge i_sclk) begin
        if (srst) begin
            o_sdo_oe <= 1'b0;
        end else begin
            o_sdo_oe <= !i_cs_n && state_r != ST_BUSY; // R3 R4
        end
    end

    // Busy counter and open-drain drive
    always_ff @(posedge i_sclk) begin
        if (srst) begin
            o_busy_n_oe <= 1'b0;
            o_busy_n_out <= 1'b0;
            busy_cnt_r <= 10'h000;
            long_r <= 1'b0;
        end else if (go.start) begin
            o_busy_n_oe <= 1'b1; // R7
            long_r <= go.long_run;
            busy_cnt_r <= go.long_run ? BUSY_LONG_CYC - 10'h001 // R9
                                      : BUSY_SHORT_CYC - 10'h001; // R8
        end else if (o_busy_n_oe) begin
            if (busy_cnt_r == 10'h000) begin
                o_busy_n_oe <= 1'b0; // R8 R9
            end else begin
                busy_cnt_r <= busy_cnt_r - 10'h001;
            end
        end
    end

    // Completed word published by toggle
    always_ff @(posedge i_sclk) begin
        if (srst) begin
            rx_hold_r <= '0;
            rx_tog_r <= 1'b0;
        end else if (state_r == ST_FRAME && i_cs_n && word_ok) begin
            rx_hold_r <= rx_sr_r;
            rx_tog_r <= ~rx_tog_r;
        end
    end

    // Transmit word taken over when its toggle arrives
    always_ff @(posedge i_sclk) begin
        if (srst) begin
            tx_tog_sync_r <= 3'h0;
            tx_buf_r <= '0;
        end else begin
            tx_tog_sync_r <= {tx_tog_sync_r[1:0], tx_tog_r};
            if (tx_tog_sync_r[2] ^ tx_tog_sync_r[1]) begin
                tx_buf_r <= tx_hold_r;
            end
        end
    end

    // Busy length tracker for checks
    always_ff @(posedge i_sclk) begin
        if (srst) begin
            busy_len_r <= 10'h000;
        end else if (go.start) begin
            busy_len_r <= 10'h001;
        end else if (o_busy_n_oe && busy_len_r != 10'h3FF) begin
            busy_len_r <= busy_len_r + 10'h001;
        end
    end

    // ****************************************************************
    // Main clock domain
    // ****************************************************************
    // Transmit word hold and toggle
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            tx_hold_r <= '0;
            tx_tog_r <= 1'b0;
        end else if (i_tx_load) begin
            tx_hold_r <= i_tx_data;
            tx_tog_r <= ~tx_tog_r;
        end
    end

    // Received word delivery
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rx_tog_sync_r <= 3'h0;
            o_rx_data <= '0;
            o_rx_valid <= 1'b0;
        end else begin
            rx_tog_sync_r <= {rx_tog_sync_r[1:0], rx_tog_r};
            o_rx_valid <= rx_tog_sync_r[2] ^ rx_tog_sync_r[1];
            if (rx_tog_sync_r[2] ^ rx_tog_sync_r[1]) begin
                o_rx_data <= rx_hold_r;
            end
        end
    end

    // Busy level status
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            busy_sync_r <= SYNC_RST;
        end else begin
            busy_sync_r <= {busy_sync_r[0], o_busy_n_oe};
        end
    end
    assign o_busy = busy_sync_r[1];

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_R1_CAPTURE: assert property (@(posedge i_sclk) disable iff (srst) // R1
        ($past(!i_cs_n) && $past(state_r) != ST_BUSY)
        |-> rx_sr_r[0] == $past(i_sdi)) else $error("sdi not captured");
    AST_R2_LAUNCH: assert property (@(posedge i_sclk) disable iff (srst) // R2
        ($past(!i_cs_n) && $past(state_r) == ST_FRAME)
        |-> o_sdo == $past(tx_sr_r[WORD_W-1])) else $error("sdo bit wrong");
    AST_R3_IDLE_Z: assert property (@(posedge i_sclk) disable iff (srst) // R3
        $past(i_cs_n) |-> !o_sdo_oe) else $error("sdo driven w/o cs");
    AST_R4_RELEASE_Z: assert property (@(posedge i_sclk) disable iff (srst) // R4
        (state_r == ST_FRAME && i_cs_n) |=> !o_sdo_oe)
        else $error("sdo still driven");
    AST_R7_ASSERT: assert property (@(posedge i_sclk) disable iff (srst) // R7
        (state_r == ST_FRAME && i_cs_n) |=> o_busy_n_oe && !o_busy_n_out)
        else $error("busy not asserted");
    AST_R8_MIN: assert property (@(posedge i_sclk) disable iff (srst) // R8
        (go.start && !go.long_run) |=> o_busy_n_oe [*3])
        else $error("busy too short");
    AST_R8_MAX: assert property (@(posedge i_sclk) disable iff (srst) // R8
        (go.start && !go.long_run) |-> ##[3:21] !o_busy_n_oe)
        else $error("busy too long");
    AST_R9_LONG: assert property (@(posedge i_sclk) disable iff (srst) // R9
        $fell(o_busy_n_oe) && $past(long_r)
        |-> $past(busy_len_r) >= BUSY_LONG_CYC)
        else $error("long busy cut short");

endmodule : spi_slave_busy_handshake

// ### spi_master_model.sv
// Behavioural serial master that frames words and clocks out busy
`timescale 1ns/1ps
module spi_master_model
    import spi_busy_pkg::*;
(
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    input wire logic i_busy_oe
);
    logic last_r = 1'h0;

    // Idle levels, clock stands low between pulses
    initial begin
        o_sclk = 1'h0;
        o_cs_n = 1'h1;
        o_sdi = 1'h0;
    end

    // One 125 ns serial clock period, odd offset to the main clock
    task pulse();
        #31.1;
        o_sclk = 1'h1;
        #62.5;
        o_sclk = 1'h0;
        #31.4;
    endtask : pulse

    // Clock on until busy has been seen and released
    task wait_busy(inout int cnt);
        for (int k = 0; k < 2000; k++) begin
            pulse();
            if (i_busy_oe)
                cnt++;
            else if (cnt > 0)
                break;
        end
    endtask : wait_busy

    // One framed word, MSB first; data changes mid low phase
    task frame(input logic [25:0] w, input int nb, output logic [25:0] rx,
               output int bcnt, output logic ok);
        rx = 26'h0000000;
        ok = 1'h1;
        // Released gap, also lets a loaded word cross into the link side
        repeat (CS_GAP_MIN_CYC) pulse();
        o_cs_n = 1'h0;
        for (int i = nb - 1; i >= 0; i--) begin
            o_sdi = w[i];
            pulse();
            ok &= i_sdo_oe;
            last_r = i_sdo_oe ? i_sdo : ~last_r;
            rx = {rx[24:0], last_r};
        end
        o_cs_n = 1'h1;
        o_sdi = ~o_sdi;
        pulse();
        ok &= !i_sdo_oe;
        ok &= i_busy_oe;
        bcnt = 1;
        wait_busy(bcnt);
    endtask : frame
endmodule : spi_master_model

// ### testbench.sv
// Self-checking bench for the serial slave with busy handshake
`timescale 1ns/1ps
module testbench;
    import spi_busy_pkg::*;
    typedef struct packed {
        logic [25:0] tx;
        logic [25:0] wr;
        logic [9:0] busy;
    } row_t;
    localparam row_t ROWS [3] = '{
        '{26'h3FFFFFF, 26'h0000000, BUSY_SHORT_CYC},
        '{26'h0000000, 26'h3FFFFFF, BUSY_SHORT_CYC},
        '{26'h1234567, 26'h2B3C4D5, BUSY_SHORT_CYC}};
    logic i_mclk = 1'h0;
    logic i_rst_n = 1'h0;
    logic tx_load = 1'h0;
    logic [25:0] tx_data = 26'h0000000;
    logic sclk, cs_n, sdi, sdo, sdo_oe, busy_oe, rx_valid, busy, ok;
    logic busy_val;
    logic seen_busy = 1'h0;
    logic [25:0] rx_data, got, seen_w;
    int n_errors, num_checks, bcnt, n_rx, cyc, k;

    spi_slave_busy_handshake dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi), .o_sdo(sdo),
        .o_sdo_oe(sdo_oe), .o_busy_n_out(busy_val), .o_busy_n_oe(busy_oe),
        .i_tx_data(tx_data), .i_tx_load(tx_load), .o_rx_data(rx_data),
        .o_rx_valid(rx_valid), .o_busy(busy));
    spi_master_model m_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi),
        .i_sdo(sdo), .i_sdo_oe(sdo_oe), .i_busy_oe(busy_oe));

    // Main clock, 40 MHz
    initial begin
        forever #12.5 i_mclk = ~i_mclk;
    end

    // Received-word monitor and run timeout
    always @(posedge i_mclk) begin
        cyc++;
        if (busy) begin
            seen_busy <= 1'h1;
        end
        if (rx_valid) begin
            seen_w <= rx_data;
            n_rx++;
        end
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task chk(input string nm, input logic [25:0] e, input logic [25:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        fork
            repeat (10) @(posedge i_mclk);
            repeat (2) m_u.pulse();
        join
        @(posedge i_mclk);
        i_rst_n <= 1'h1;
        bcnt = 0;
        m_u.wait_busy(bcnt);
        chk("reset busy", 26'(BUSY_LONG_CYC), 26'(bcnt));
        chk("busy level", 26'h0000001, {25'h0, seen_busy});
        $display("reset test done");
        foreach (ROWS[i]) begin
            @(posedge i_mclk);
            tx_data <= ROWS[i].tx;
            tx_load <= 1'h1;
            @(posedge i_mclk);
            tx_load <= 1'h0;
            repeat (20) @(posedge i_mclk);
            k = n_rx;
            m_u.frame(ROWS[i].wr, 26, got, bcnt, ok);
            chk("master rx", ROWS[i].tx, got);
            chk("dut rx", ROWS[i].wr, seen_w);
            chk("rx count", 26'(k + 1), 26'(n_rx));
            chk("busy width", 26'(ROWS[i].busy), 26'(bcnt));
            chk("drive", 26'h0000001, {25'h0, ok});
            chk("busy sync", 26'h0000000, {25'h0, busy});
            chk("busy pin", 26'h0000000, {25'h0, busy_val});
            $display("row %0d test done", i);
        end
        k = n_rx;
        m_u.frame(26'h1555555, 25, got, bcnt, ok);
        chk("short rx count", 26'(k), 26'(n_rx));
        chk("short busy", 26'(BUSY_SHORT_CYC), 26'(bcnt));
        $display("short word test done");
        m_u.frame(26'h2A5A5A5, 26, got, bcnt, ok);
        chk("soft busy", 26'(BUSY_LONG_CYC), 26'(bcnt));
        chk("soft drive", 26'h0000001, {25'h0, ok});
        chk("soft rx", 26'h2A5A5A5, seen_w);
        $display("soft reset test done");
        test_done();
    end
endmodule : testbench
